// *** verilog/occr_oscillator_control.v ***
// oscillator control register with decoded controls and clock inversion
`timescale 1ns/1ps
`default_nettype none
`include "occr_defines.vh"
module occr_oscillator_control (
   input  wire       mclk_i,
   input  wire       reset_i,
   input  wire [7:0] addr_i,
   input  wire [7:0] wdata_i,
   input  wire       wr_en_i,
   output reg  [7:0] rdata_o,
   input  wire       stopwatch_mode_i,
   input  wire       sel_clk_i,
   output wire       clk_out_o,
   output reg        output_clock_invert_o,
   output reg        offset_mode_select_o,
   output reg        hour12_active_o,
   output reg        low_jitter_select_o,
   output reg  [1:0] crystal_drive_level_o,
   output reg  [1:0] load_cap_select_o
);

   // stored register image and its next value
   reg  [7:0] osc_ctrl_reg;
   reg  [7:0] osc_ctrl_next;
   // next value of the registered read data
   reg  [7:0] rdata_next;
   // two-stage synchroniser for the selected-frequency clock
   reg        sel_clk_meta_reg;
   reg        sel_clk_sync_reg;
   // output clock flop and its next value
   reg        clk_out_reg;
   reg        clk_out_next;
   // next values of the decoded controls
   reg        invert_next;
   reg        offset_mode_select_next;
   reg        hour12_next;
   reg        low_jitter_select_next;
   reg  [1:0] drive_next;
   reg  [1:0] cap_next;
   // address decode of the single mapped location
   wire       addr_hit;
   wire       write_hit;

   // true when an address selects the oscillator control location
   function addr_match;
      input [7:0] addr;
      begin
         addr_match = (addr == `OCCR_ADDR);
      end
   endfunction

   // two-bit select fields: codes 10 and 11 mean the same top setting,
   // so the analog side only ever sees three distinct codes
   function [1:0] fold_top_code;
      input [1:0] code;
      begin
         case (code)
            2'h0:    fold_top_code = 2'h0;
            2'h1:    fold_top_code = 2'h1;
            2'h2:    fold_top_code = 2'h2;
            2'h3:    fold_top_code = 2'h2;
            default: fold_top_code = 2'h0;
         endcase
      end
   endfunction

   // address and write decode shared by the store and the read path
   assign addr_hit  = addr_match(addr_i);
   assign write_hit = wr_en_i & addr_match(addr_i);

   // next image: a mapped write stores all eight bits raw
   always @* begin
      osc_ctrl_next = osc_ctrl_reg;
      if (write_hit) begin
         osc_ctrl_next = wdata_i;
      end
   end

   // register image; reset loads every default
   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         osc_ctrl_reg <= `OCCR_RESET;
      end else begin
         osc_ctrl_reg <= osc_ctrl_next;
      end
   end

   // read data: stored image when mapped, zero elsewhere
   always @* begin
      rdata_next = 8'h00;
      if (addr_hit) begin
         rdata_next = osc_ctrl_reg;
      end
   end

   // read data flop; a read in the write cycle still shows the old value
   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         rdata_o <= 8'h00;
      end else begin
         rdata_o <= rdata_next;
      end
   end

   // first synchroniser stage; only the second stage reads it
   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         sel_clk_meta_reg <= 1'b0;
      end else begin
         sel_clk_meta_reg <= sel_clk_i;
      end
   end

   // second synchroniser stage, safe for logic to read
   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         sel_clk_sync_reg <= 1'b0;
      end else begin
         sel_clk_sync_reg <= sel_clk_meta_reg;
      end
   end

   // inversion of the selected clock; a set bit moves the clean edge
   always @* begin
      clk_out_next = sel_clk_sync_reg ^
                     osc_ctrl_reg[`OCCR_BIT_INVERT];
   end

   // output clock flop, so the pin never sees a decode glitch
   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         clk_out_reg <= 1'b0;
      end else begin
         clk_out_reg <= clk_out_next;
      end
   end

   assign clk_out_o = clk_out_reg;

   // single-bit controls copied from the image
   always @* begin
      invert_next = osc_ctrl_reg[`OCCR_BIT_INVERT];
      offset_mode_select_next   = osc_ctrl_reg[`OCCR_BIT_OFFSET_MODE_SELECT];
      low_jitter_select_next   = osc_ctrl_reg[`OCCR_BIT_LOW_JITTER_SELECT];
   end

   // twelve-hour counting only outside stop-watch mode
   always @* begin
      hour12_next = 1'b0;
      if (!stopwatch_mode_i) begin
         hour12_next = osc_ctrl_reg[`OCCR_BIT_HOUR12];
      end
   end

   // drive and capacitance fields with their top codes folded
   always @* begin
      drive_next = fold_top_code({osc_ctrl_reg[`OCCR_DRIVE_HI],
                                  osc_ctrl_reg[`OCCR_DRIVE_LO]});
      cap_next   = fold_top_code({osc_ctrl_reg[`OCCR_CAP_HI],
                                  osc_ctrl_reg[`OCCR_CAP_LO]});
   end

   // clock invert control flop
   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         output_clock_invert_o <= 1'b0;
      end else begin
         output_clock_invert_o <= invert_next;
      end
   end

   // offset calibration mode flop, passed on to the calibration logic
   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         offset_mode_select_o <= 1'b0;
      end else begin
         offset_mode_select_o <= offset_mode_select_next;
      end
   end

   // hour format flop for the time counters
   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         hour12_active_o <= 1'b0;
      end else begin
         hour12_active_o <= hour12_next;
      end
   end

   // low jitter control flop
   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         low_jitter_select_o <= 1'b0;
      end else begin
         low_jitter_select_o <= low_jitter_select_next;
      end
   end

   // crystal drive level flop
   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         crystal_drive_level_o <= `OCCR_DRIVE_NORMAL;
      end else begin
         crystal_drive_level_o <= drive_next;
      end
   end

   // load capacitance flop
   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         load_cap_select_o <= `OCCR_CAP_7P0;
      end else begin
         load_cap_select_o <= cap_next;
      end
   end

endmodule
`default_nettype wire

// *** verilog/occr_defines.vh ***
// constants for the oscillator control register block
`ifndef OCCR_DEFINES_VH
`define OCCR_DEFINES_VH
`define OCCR_ADDR          8'h25
`define OCCR_RESET         8'h00
`define OCCR_BIT_INVERT    7
`define OCCR_BIT_OFFSET_MODE_SELECT      6
`define OCCR_BIT_HOUR12    5
`define OCCR_BIT_LOW_JITTER_SELECT      4
`define OCCR_DRIVE_HI      3
`define OCCR_DRIVE_LO      2
`define OCCR_CAP_HI        1
`define OCCR_CAP_LO        0
`define OCCR_DRIVE_NORMAL  2'h0
`define OCCR_DRIVE_LOW     2'h1
`define OCCR_DRIVE_HIGH    2'h2
`define OCCR_CAP_7P0       2'h0
`define OCCR_CAP_6P0       2'h1
`define OCCR_CAP_12P5      2'h2
`endif

// *** dv/occr_monitor.sv ***
// port checker for the oscillator control register
`timescale 1ns/1ps
`default_nettype none
module occr_monitor (
   input wire logic       mclk_i,
   input wire logic       reset_i,
   input wire logic       wr_en_i,
   input wire logic       stopwatch_mode_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic [7:0] rdata_o,
   input wire logic       hour12_active_o,
   input wire logic       output_clock_invert_o,
   input wire logic       low_jitter_select_o,
   input wire logic [1:0] crystal_drive_level_o,
   input wire logic [1:0] load_cap_select_o
);
   wire w = wr_en_i & (addr_i == 8'h25);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   a_inv_copy: assert property (w |-> ##2
      output_clock_invert_o == $past(wdata_i[7], 2)) else $error("inv");
   a_low_jitter_select_copy: assert property (w |-> ##2
      low_jitter_select_o == $past(wdata_i[4], 2)) else $error("low_jitter_select");
   a_hour_sel: assert property (w ##1 !stopwatch_mode_i |=>
      hour12_active_o == $past(wdata_i[5], 2)) else $error("hour");
   a_sw_ignore: assert property (stopwatch_mode_i |=>
      !hour12_active_o) else $error("sw");
   a_drive_high: assert property (w && wdata_i[3] |-> ##2
      crystal_drive_level_o == 2'h2) else $error("drv");
   a_cap_high: assert property (w && wdata_i[1] |-> ##2
      load_cap_select_o == 2'h2) else $error("cap");
   a_read_back: assert property (w ##1 addr_i == 8'h25 |=>
      rdata_o == $past(wdata_i, 2)) else $error("rd");
   a_unmapped_zero: assert property (addr_i != 8'h25 |=>
      rdata_o == 8'h00) else $error("map");
   cover property (w && wdata_i[3]);
   cover property (w && stopwatch_mode_i);
   cover property (wr_en_i && addr_i != 8'h25);
endmodule
bind occr_oscillator_control occr_monitor mon_u (.*);
`default_nettype wire

// *** dv/occr_oscillator_control_tb.sv ***
// bench for the oscillator control register
`timescale 1ns/1ps
`default_nettype none
module occr_oscillator_control_tb;
   logic mclk_i = 0, reset_i = 1, w_i = 0, sw_i = 0, s_i = 0;
   logic [7:0] a_i = 0, d_i = 0;
   wire [16:0] q;
   int err_count = 0, n_checks = 0;
   occr_oscillator_control dut_u (.mclk_i, .reset_i, .addr_i(a_i),
      .wdata_i(d_i), .wr_en_i(w_i), .stopwatch_mode_i(sw_i), .sel_clk_i(s_i),
      .rdata_o(q[16:9]), .clk_out_o(q[8]), .output_clock_invert_o(q[7]),
      .offset_mode_select_o(q[6]), .hour12_active_o(q[5]),
      .low_jitter_select_o(q[4]), .crystal_drive_level_o(q[3:2]),
      .load_cap_select_o(q[1:0]));
   initial forever #50 mclk_i = ~mclk_i;
   initial #20000 results(1);
   task results(input int t);
      err_count += t;
      if (err_count == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // one write, then read data, clock output and decoded controls at once
   task wr(input logic [7:0] a, d, e);
      @(negedge mclk_i) {a_i, d_i, w_i, s_i} = {a, d, 1'b1, ~s_i};
      repeat (4) @(negedge mclk_i) w_i = 0;
      n_checks++;
      if (q !== {a == 8'h25 ? e : 8'h00, s_i ^ e[7], e[7:6], e[5] & ~sw_i,
         e[4], e[3] ? 2'h2 : e[3:2], e[1] ? 2'h2 : e[1:0]}) begin
         err_count++;
         $display("mismatch %0t q=%h", $time, q);
      end
   endtask
   initial begin
      repeat (4) @(negedge mclk_i);
      reset_i = 0;
      wr(8'h30, 8'h00, 8'h00);
      for (int i = 0; i < 4; i++) wr(8'h25, 8'(8'h55 * i), 8'(8'h55 * i));
      wr(8'h24, 8'h12, 8'hff);
      wr(8'h25, 8'h10, 8'h10);
      sw_i = 1;
      wr(8'h25, 8'hff, 8'hff);
      results(0);
   end
endmodule
`default_nettype wire
